/* File: src/ipmc_map.svh */
`ifndef IPMC_MAP_SVH
`define IPMC_MAP_SVH

// register byte offsets on the control bus
`define IPMC_OFS_OUT 8'h00
`define IPMC_OFS_MAPA 8'h04
`define IPMC_OFS_MAPB 8'h08
`define IPMC_OFS_PWMA 8'h0c
`define IPMC_OFS_PWMB 8'h10
`define IPMC_OFS_INLVL 8'h14
`define IPMC_OFS_MODE 8'h18

// reset values: input a on channel 2, input b on channel 3
`define IPMC_RST_OUT 8'h00
`define IPMC_RST_MAPA 8'h04
`define IPMC_RST_MAPB 8'h08
`define IPMC_RST_PWM 8'h00

// default channel index of each direct input
`define IPMC_CH_DFLT_A 2
`define IPMC_CH_DFLT_B 3

// mode status field positions
`define IPMC_MODE_LIMP_BIT 0
`define IPMC_MODE_SLEEP_BIT 1

// bus answers
`define IPMC_RESP_OKAY 2'h0
`define IPMC_RESP_SLVERR 2'h2
`define IPMC_RESP_DECERR 2'h3

`endif

/* File: src/ipmc_pkg.sv */
package ipmc_pkg;

  // operating mode chosen by the idle pin and the direct inputs
  typedef enum logic [1:0] {
    IPMC_NORMAL,
    IPMC_LIMP,
    IPMC_SLEEP
  } ipmc_mode_t;

  typedef logic [7:0] ipmc_chan_t;

endpackage : ipmc_pkg

/* File: src/ipmc_mode_ctrl.sv */
`timescale 1ns/10ps

module ipmc_mode_ctrl (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic idle_pin, // low asks for sleep or limp-home
  input wire logic direct_input_a, // first direct input pin
  input wire logic direct_input_b, // second direct input pin
  output ipmc_pkg::ipmc_mode_t mode_q // current operating mode
);

  ipmc_pkg::ipmc_mode_t mode_d;

  // next mode decoded straight from the pins every cycle
  always_comb
  begin
    mode_d = ipmc_pkg::IPMC_NORMAL;
    unique case ({idle_pin, direct_input_a | direct_input_b})
      2'h0: mode_d = ipmc_pkg::IPMC_SLEEP;
      2'h1: mode_d = ipmc_pkg::IPMC_LIMP;
      2'h2, 2'h3: mode_d = ipmc_pkg::IPMC_NORMAL;
    endcase
  end

  // the host holds the idle pin for the transition time, so no filter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_q <= ipmc_pkg::IPMC_NORMAL;
    else
      mode_q <= mode_d;
  end

endmodule : ipmc_mode_ctrl

/* File: src/ipmc_top.sv */
`timescale 1ns/10ps
`include "ipmc_map.svh"

module ipmc_top (
  input wire logic aclk, // 250 MHz clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic idle_pin, // low: sleep or limp-home
  input wire logic direct_input_a, // first direct input
  input wire logic direct_input_b, // second direct input
  input wire logic pwm_gen_a, // first pwm generator output
  input wire logic pwm_gen_b, // second pwm generator output
  output logic [7:0] channel_drive, // per channel on request
  output logic uv_detect_en, // undervoltage detectors enabled
  output logic serial_out_en, // serial data output may drive
  output logic limp_mode, // device in limp-home
  output logic sleep_mode // device in sleep
);

  ipmc_pkg::ipmc_mode_t mode_q;
  ipmc_pkg::ipmc_chan_t out_q, map_a_q, map_b_q, pwm_a_q, pwm_b_q;
  ipmc_pkg::ipmc_chan_t drive_d, channel_drive_q;
  logic [1:0] in_level_q;
  logic regs_clear;
  logic aw_ready_q, w_ready_q, aw_held_q, w_held_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic b_valid_q, ar_ready_q, r_valid_q;
  logic [1:0] b_resp_q, r_resp_q, b_resp_d, r_resp_d;
  logic [31:0] r_data_q, r_data_d;
  logic wr_fire, rd_fire, bus_open;
  logic uv_en_q, ser_en_q;

  ipmc_mode_ctrl u_mode (
    .aclk(aclk),
    .aresetn(aresetn),
    .idle_pin(idle_pin),
    .direct_input_a(direct_input_a),
    .direct_input_b(direct_input_b),
    .mode_q(mode_q)
  );

  // registers are held at default whenever the idle pin is low
  assign regs_clear = !aresetn || !idle_pin;
  // sleep blocks the bus; limp still allows reads of the monitor
  assign bus_open = (mode_q != ipmc_pkg::IPMC_SLEEP);

  // write address channel, taken once per write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ready_q <= 1'b0;
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end
    else if (s_axi_awvalid && aw_ready_q)
    begin
      aw_ready_q <= 1'b0;
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_q <= 1'b0;
    else if (!aw_held_q && !b_valid_q)
      aw_ready_q <= 1'b1;
  end

  // write data channel, independent of the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_ready_q <= 1'b0;
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end
    else if (s_axi_wvalid && w_ready_q)
    begin
      w_ready_q <= 1'b0;
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata[7:0];
      w_strb_q <= s_axi_wstrb[0];
    end
    else if (wr_fire)
      w_held_q <= 1'b0;
    else if (!w_held_q && !b_valid_q)
      w_ready_q <= 1'b1;
  end

  assign wr_fire = aw_held_q && w_held_q && !b_valid_q;

  // response code for the pending write
  always_comb
  begin
    b_resp_d = `IPMC_RESP_DECERR;
    if (!bus_open)
      b_resp_d = `IPMC_RESP_SLVERR;
    else if (aw_addr_q == `IPMC_OFS_OUT || aw_addr_q == `IPMC_OFS_MAPA ||
             aw_addr_q == `IPMC_OFS_MAPB || aw_addr_q == `IPMC_OFS_PWMA ||
             aw_addr_q == `IPMC_OFS_PWMB || aw_addr_q == `IPMC_OFS_INLVL ||
             aw_addr_q == `IPMC_OFS_MODE)
      b_resp_d = `IPMC_RESP_OKAY;
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      b_valid_q <= 1'b0;
      b_resp_q <= `IPMC_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      b_valid_q <= 1'b1;
      b_resp_q <= b_resp_d;
    end
    else if (s_axi_bready)
      b_valid_q <= 1'b0;
  end

  // software registers; limp and sleep both keep them at default
  always_ff @(posedge aclk)
  begin
    if (regs_clear)
    begin
      out_q <= `IPMC_RST_OUT;
      map_a_q <= `IPMC_RST_MAPA;
      map_b_q <= `IPMC_RST_MAPB;
      pwm_a_q <= `IPMC_RST_PWM;
      pwm_b_q <= `IPMC_RST_PWM;
    end
    else if (wr_fire && w_strb_q && bus_open)
    begin
      // read-only offsets fall through silently with an okay answer
      unique case (aw_addr_q)
        `IPMC_OFS_OUT: out_q <= w_data_q;
        `IPMC_OFS_MAPA: map_a_q <= w_data_q;
        `IPMC_OFS_MAPB: map_b_q <= w_data_q;
        `IPMC_OFS_PWMA: pwm_a_q <= w_data_q;
        `IPMC_OFS_PWMB: pwm_b_q <= w_data_q;
        default: ;
      endcase
    end
  end

  // input level monitor, never frozen by mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      in_level_q <= 2'h0;
    else
      in_level_q <= {direct_input_b, direct_input_a};
  end

  // read data and response selection
  always_comb
  begin
    r_data_d = 32'h0000_0000;
    r_resp_d = `IPMC_RESP_OKAY;
    if (!bus_open)
      r_resp_d = `IPMC_RESP_SLVERR;
    else
    begin
      unique case (s_axi_araddr)
        `IPMC_OFS_OUT: r_data_d[7:0] = out_q;
        `IPMC_OFS_MAPA: r_data_d[7:0] = map_a_q;
        `IPMC_OFS_MAPB: r_data_d[7:0] = map_b_q;
        `IPMC_OFS_PWMA: r_data_d[7:0] = pwm_a_q;
        `IPMC_OFS_PWMB: r_data_d[7:0] = pwm_b_q;
        `IPMC_OFS_INLVL: r_data_d[1:0] = in_level_q;
        `IPMC_OFS_MODE:
        begin
          r_data_d[`IPMC_MODE_LIMP_BIT] = (mode_q == ipmc_pkg::IPMC_LIMP);
          r_data_d[`IPMC_MODE_SLEEP_BIT] = (mode_q == ipmc_pkg::IPMC_SLEEP);
        end
        default: r_resp_d = `IPMC_RESP_DECERR;
      endcase
    end
  end

  assign rd_fire = s_axi_arvalid && ar_ready_q;

  // read channel: one read in flight, answer one cycle after address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ar_ready_q <= 1'b0;
      r_valid_q <= 1'b0;
      r_data_q <= 32'h0000_0000;
      r_resp_q <= `IPMC_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      ar_ready_q <= 1'b0;
      r_valid_q <= 1'b1;
      r_data_q <= r_data_d;
      r_resp_q <= r_resp_d;
    end
    else if (r_valid_q && s_axi_rready)
      r_valid_q <= 1'b0;
    else if (!r_valid_q)
      ar_ready_q <= 1'b1;
  end

  // per channel drive, recomputed from the live pins every cycle
  for (genvar i = 0; i < 8; i++)
  begin : g_chan
    always_comb
    begin
      drive_d[i] = 1'b0;
      unique case (mode_q)
        ipmc_pkg::IPMC_NORMAL:
          drive_d[i] = out_q[i] | (pwm_gen_a & pwm_a_q[i]) |
                       (pwm_gen_b & pwm_b_q[i]) |
                       (direct_input_a & map_a_q[i]) |
                       (direct_input_b & map_b_q[i]);
        ipmc_pkg::IPMC_LIMP:
          drive_d[i] = (direct_input_a && i == `IPMC_CH_DFLT_A) ||
                       (direct_input_b && i == `IPMC_CH_DFLT_B);
        ipmc_pkg::IPMC_SLEEP:
          drive_d[i] = 1'b0;
        default: drive_d[i] = 1'b0;
      endcase
    end
  end

  // channel outputs from a flop; in limp-home the pins alone drive them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      channel_drive_q <= 8'h00;
    else
      channel_drive_q <= drive_d;
  end

  // supervision and serial output enables follow the mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      uv_en_q <= 1'b1;
      ser_en_q <= 1'b1;
    end
    else
    begin
      uv_en_q <= (mode_q != ipmc_pkg::IPMC_SLEEP);
      ser_en_q <= (mode_q != ipmc_pkg::IPMC_SLEEP);
    end
  end

  // mode flags brought out through flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      limp_mode <= 1'b0;
      sleep_mode <= 1'b0;
    end
    else
    begin
      limp_mode <= (mode_q == ipmc_pkg::IPMC_LIMP);
      sleep_mode <= (mode_q == ipmc_pkg::IPMC_SLEEP);
    end
  end

  assign s_axi_awready = aw_ready_q;
  assign s_axi_wready = w_ready_q;
  assign s_axi_bvalid = b_valid_q;
  assign s_axi_bresp = b_resp_q;
  assign s_axi_arready = ar_ready_q;
  assign s_axi_rvalid = r_valid_q;
  assign s_axi_rdata = r_data_q;
  assign s_axi_rresp = r_resp_q;
  assign channel_drive = channel_drive_q;
  assign uv_detect_en = uv_en_q;
  assign serial_out_en = ser_en_q;

  // checks on mode, drive and bus behaviour
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_default_map: assert property (
    !idle_pin |=> map_a_q == `IPMC_RST_MAPA && map_b_q == `IPMC_RST_MAPB)
    else $error("input maps not at default after idle low");

  a_map_drives_chan: assert property (
    (mode_q == ipmc_pkg::IPMC_NORMAL && direct_input_a && map_a_q[5])
    |=> channel_drive[5])
    else $error("mapped input a did not drive channel 5");

  a_or_out_bit: assert property (
    (mode_q == ipmc_pkg::IPMC_NORMAL && out_q[7]) |=> channel_drive[7])
    else $error("output bit did not reach channel 7");

  a_monitor_tracks: assert property (
    (mode_q == ipmc_pkg::IPMC_LIMP) |=>
    in_level_q == $past({direct_input_b, direct_input_a}))
    else $error("input level monitor stale");

  a_limp_default_chan: assert property (
    (!idle_pin && direct_input_a) ##1 direct_input_a
    |=> channel_drive[`IPMC_CH_DFLT_A] && limp_mode)
    else $error("limp-home did not switch default channel");

  a_sleep_entry: assert property (
    (!idle_pin && !direct_input_a && !direct_input_b) ##1 1'b1
    |=> sleep_mode && channel_drive == 8'h00)
    else $error("sleep not entered with both inputs low");

  a_idle_clears_out: assert property (
    !idle_pin |=> out_q == `IPMC_RST_OUT)
    else $error("output register survived idle low");

  a_uv_off_sleep: assert property (
    (mode_q == ipmc_pkg::IPMC_SLEEP) |=> !uv_detect_en)
    else $error("undervoltage detectors on in sleep");

  a_sleep_refuse: assert property (
    (wr_fire && mode_q == ipmc_pkg::IPMC_SLEEP)
    |=> s_axi_bvalid && s_axi_bresp == `IPMC_RESP_SLVERR && !serial_out_en)
    else $error("bus write accepted in sleep");

  a_normal_on_idle: assert property (
    idle_pin |=> mode_q == ipmc_pkg::IPMC_NORMAL)
    else $error("idle high did not give normal mode");

  c_limp_seen: cover property (limp_mode && channel_drive != 8'h00);
  c_sleep_seen: cover property (sleep_mode ##1 !sleep_mode);
  c_write_ok: cover property (
    s_axi_bvalid && s_axi_bresp == `IPMC_RESP_OKAY);

endmodule : ipmc_top

/* File: test/ipmc_host_model.sv */
`timescale 1ns/10ps

// host side of the control pins
module ipmc_host_model #(
  parameter int HOLD_CYC = 4
) (
  input wire logic aclk, // system clock
  output logic idle_pin, // low asks for sleep or limp
  output logic direct_input_a, // first direct input
  output logic direct_input_b // second direct input
);
  // idle high and inputs low: normal mode, nothing forced
  initial
  begin
    idle_pin = 1'b1;
    direct_input_a = 1'b0;
    direct_input_b = 1'b0;
  end

  // levels launch after an edge and stay put so the mode change lands
  task automatic drive(input logic idle, input logic a, input logic b);
    @(posedge aclk);
    idle_pin <= idle;
    direct_input_a <= a;
    direct_input_b <= b;
    repeat (HOLD_CYC) @(posedge aclk);
  endtask : drive
endmodule : ipmc_host_model

/* File: test/ipmc_top_tb.sv */
`timescale 1ns/10ps
`include "ipmc_map.svh"

module ipmc_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic idle_pin, direct_input_a, direct_input_b;
  logic pwm_gen_a = 1'b0, pwm_gen_b = 1'b0;
  logic [7:0] channel_drive;
  logic uv_detect_en, serial_out_en, limp_mode, sleep_mode;
  int err_count = 0;
  int checks_done = 0;

  ipmc_top u_ipmc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .idle_pin,
    .direct_input_a, .direct_input_b, .pwm_gen_a, .pwm_gen_b,
    .channel_drive, .uv_detect_en, .serial_out_en, .limp_mode,
    .sleep_mode);

  ipmc_host_model u_ipmc_host_model (.aclk, .idle_pin, .direct_input_a,
    .direct_input_b);

  // 250 mhz
  always #2 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // write: address and data offered together, each released when taken
  task automatic wr_chk(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] exp_resp);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 64);
    chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
    chk("bresp", {30'h0, exp_resp}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr_chk

  // read: data and answer taken at the edge where rvalid is seen
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
    input logic [1:0] exp_resp);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 64);
    chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
    chk("rdata", {24'h0, exp}, s_axi_rdata);
    chk("rresp", {30'h0, exp_resp}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd_chk

  task automatic chk_pins(input logic [7:0] drv, input logic [3:0] flg);
    chk("drive", {24'h0, drv}, {24'h0, channel_drive});
    chk("flags", {28'h0, flg}, {28'h0, uv_detect_en, serial_out_en,
      limp_mode, sleep_mode});
  endtask : chk_pins

  task automatic t_defaults;
    rd_chk(`IPMC_OFS_MAPA, `IPMC_RST_MAPA, `IPMC_RESP_OKAY);
    rd_chk(`IPMC_OFS_MAPB, `IPMC_RST_MAPB, `IPMC_RESP_OKAY);
    u_ipmc_host_model.drive(1'b1, 1'b1, 1'b1);
    chk_pins(8'h0c, 4'hc);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_map_or;
    wr_chk(`IPMC_OFS_MAPA, 8'h31, `IPMC_RESP_OKAY);
    wr_chk(`IPMC_OFS_OUT, 8'h80, `IPMC_RESP_OKAY);
    wr_chk(`IPMC_OFS_PWMB, 8'h20, `IPMC_RESP_OKAY);
    pwm_gen_b <= 1'b1;
    u_ipmc_host_model.drive(1'b1, 1'b1, 1'b0);
    chk_pins(8'hb1, 4'hc);
    u_ipmc_host_model.drive(1'b1, 1'b0, 1'b0);
    chk_pins(8'ha0, 4'hc);
    rd_chk(8'h1c, 8'h00, `IPMC_RESP_DECERR);
    wr_chk(8'h1c, 8'h55, `IPMC_RESP_DECERR);
    // low byte strobe off: answered okay but nothing lands
    s_axi_wstrb <= 4'he;
    wr_chk(`IPMC_OFS_OUT, 8'h01, `IPMC_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd_chk(`IPMC_OFS_OUT, 8'h80, `IPMC_RESP_OKAY);
    $display("test map and or done");
  endtask : t_map_or

  task automatic t_monitor;
    u_ipmc_host_model.drive(1'b1, 1'b0, 1'b1);
    rd_chk(`IPMC_OFS_INLVL, 8'h02, `IPMC_RESP_OKAY);
    rd_chk(`IPMC_OFS_MODE, 8'h00, `IPMC_RESP_OKAY);
    $display("test monitor done");
  endtask : t_monitor

  // limp-home: mapping written earlier must fall back to defaults
  task automatic t_limp;
    u_ipmc_host_model.drive(1'b0, 1'b1, 1'b0);
    chk_pins(8'h04, 4'hc | 4'h2);
    rd_chk(`IPMC_OFS_MAPA, `IPMC_RST_MAPA, `IPMC_RESP_OKAY);
    rd_chk(`IPMC_OFS_INLVL, 8'h01, `IPMC_RESP_OKAY);
    wr_chk(`IPMC_OFS_OUT, 8'hff, `IPMC_RESP_OKAY);
    rd_chk(`IPMC_OFS_OUT, 8'h00, `IPMC_RESP_OKAY);
    u_ipmc_host_model.drive(1'b0, 1'b1, 1'b1);
    chk_pins(8'h0c, 4'he);
    rd_chk(`IPMC_OFS_INLVL, 8'h03, `IPMC_RESP_OKAY);
    $display("test limp done");
  endtask : t_limp

  task automatic t_sleep;
    u_ipmc_host_model.drive(1'b0, 1'b0, 1'b0);
    chk_pins(8'h00, 4'h1);
    wr_chk(`IPMC_OFS_MAPA, 8'h01, `IPMC_RESP_SLVERR);
    rd_chk(`IPMC_OFS_MAPA, 8'h00, `IPMC_RESP_SLVERR);
    u_ipmc_host_model.drive(1'b1, 1'b1, 1'b0);
    chk_pins(8'h04, 4'hc);
    $display("test sleep and wake done");
  endtask : t_sleep

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // watchdog well past the expected hundred-odd cycles
  initial
  begin
    #40000;
    err_count++;
    close_out();
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_defaults();
    t_map_or();
    t_monitor();
    t_limp();
    t_sleep();
    close_out();
  end
endmodule : ipmc_top_tb
